// File: logic/cmrc_defines.svh
// offsets, fields, reset values and timing counts of the clock and mode controller
`ifndef CMRC_DEFINES_SVH
`define CMRC_DEFINES_SVH

`define CMRC_AXI_AW 16
`define CMRC_IDX_W 14
// register indices; byte address is four times the index
`define CMRC_MODE_IDX 14'h00ca
`define CMRC_CFG_IDX 14'h00cb
`define CMRC_STAT_IDX 14'h00cc

`define CMRC_HIGH_OSC_STOP_BIT 1
`define CMRC_CLOCK_SOURCE_SELECT_BIT 2
`define CMRC_CPUM_LO 3
`define CMRC_CPUM_HI 4
`define CMRC_MODE_RST 4'h0

`define CMRC_CPUM_NORMAL 2'h0
`define CMRC_CPUM_SLEEP 2'h1
`define CMRC_CPUM_GREEN 2'h2

`define CMRC_CFG_NSEL_LO 0
`define CMRC_CFG_NSEL_HI 1
`define CMRC_CFG_NF_BIT 2
`define CMRC_CFG_RST_BIT 3
`define CMRC_CFG_WDT_BIT 4

`define CMRC_RESP_OKAY 2'h0
`define CMRC_RESP_SLVERR 2'h2

`define CMRC_CLK_PS 4000
`define CMRC_HIGH_CLOCK_OPTION_KHZ 6000
`define CMRC_LOSC_KHZ 32
`define CMRC_HIGH_CLOCK_OPTION_CYC (1000000000 / (`CMRC_HIGH_CLOCK_OPTION_KHZ * `CMRC_CLK_PS))
`define CMRC_LOSC_CYC (1000000000 / (`CMRC_LOSC_KHZ * `CMRC_CLK_PS))
`define CMRC_WAKE_TICKS 2048
`define CMRC_WARM_TICKS 2048
`define CMRC_LOW_DIV 2'h3

`endif

// File: logic/cmrc_pkg.sv
// types of the clock and mode controller
package cmrc_pkg;

  typedef enum logic [4:0] {
    ST_HOLD = 5'h01,
    ST_INIT = 5'h02,
    ST_WARM = 5'h04,
    ST_RUN = 5'h08,
    ST_WAKE = 5'h10
  } cmrc_state_t;

  typedef struct packed {
    logic [1:0] cpu_operating_mode;
    logic clock_source_select;
    logic high_osc_stop;
  } cmrc_mode_t;

  typedef struct packed {
    logic wdt_en;
    logic rst_pin_en;
    logic noise_filter;
    logic [1:0] fcpu_nsel;
  } cmrc_cfg_t;

  typedef struct packed {
    logic sys_reset_n;
    logic fetch_start;
    logic cpu_run;
    logic fcpu_tick;
    logic wdt_tick;
    logic high_osc_en;
    logic low_osc_en;
    logic sys_clk_src;
  } cmrc_clk_out_t;

  typedef struct packed {
    cmrc_state_t st;
    cmrc_mode_t mode;
    cmrc_cfg_t cfg;
    logic pin_s1;
    logic pin_s2;
    logic wk_s1;
    logic wk_s2;
    logic [12:0] hcnt;
    logic [12:0] lcnt;
    logic [1:0] fcnt;
    logic [12:0] wcnt;
    cmrc_clk_out_t o;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [13:0] widx;
    logic [7:0] wdat;
    logic wstb;
  } cmrc_regs_t;

endpackage : cmrc_pkg

// File: logic/cmrc_top.sv
// clock source, cpu mode and external reset sequencing with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "cmrc_defines.svh"

module cmrc_top #(
  parameter int HIGH_CLOCK_OPTION_DIV = `CMRC_HIGH_CLOCK_OPTION_CYC,
  parameter int LOSC_DIV = `CMRC_LOSC_CYC,
  parameter int WAKE_TICKS = `CMRC_WAKE_TICKS,
  parameter int WARM_TICKS = `CMRC_WARM_TICKS,
  parameter logic [1:0] FCPU_NSEL = 2'h3,
  parameter logic NOISE_FILTER = 1'b0,
  parameter logic RESET_PIN_EN = 1'b1,
  parameter logic WDT_EN = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CMRC_AXI_AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`CMRC_AXI_AW-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic ext_reset_pin_n,
  input wire logic wake_pin,
  output cmrc_pkg::cmrc_clk_out_t clk_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // free divider: wraps at lim-1, holds while disabled
  function automatic logic [12:0] div_step(
    input logic [12:0] cnt,
    input logic [12:0] lim,
    input logic en
  );
    logic [12:0] r;
    r = cnt;
    if (en)
    begin
      if (cnt >= lim - 13'h0001)
        r = 13'h0000;
      else
        r = cnt + 13'h0001;
    end
    return r;
  endfunction : div_step

  // 0 mode, 1 cfg, 2 status, 3 unmapped
  function automatic logic [1:0] reg_sel(input logic [`CMRC_IDX_W-1:0] idx);
    logic [1:0] r;
    r = 2'h3;
    if (idx == `CMRC_MODE_IDX)
      r = 2'h0;
    else if (idx == `CMRC_CFG_IDX)
      r = 2'h1;
    else if (idx == `CMRC_STAT_IDX)
      r = 2'h2;
    return r;
  endfunction : reg_sel

  localparam logic [12:0] HLIM = 13'(HIGH_CLOCK_OPTION_DIV);
  localparam logic [12:0] LLIM = 13'(LOSC_DIV);
  localparam logic [12:0] WAKE_LIM = 13'(WAKE_TICKS);
  localparam logic [12:0] WARM_LIM = 13'(WARM_TICKS);

  cmrc_pkg::cmrc_regs_t s;
  cmrc_pkg::cmrc_regs_t next_s;

  logic sleep;
  logic green;
  logic executing;
  logic hi_tick;
  logic lo_tick;
  logic src_tick;
  logic new_tick;
  logic [1:0] div_lim;
  logic [1:0] rsel;
  logic [1:0] wsel;
  logic [31:0] rval;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_s = s;
    next_s.o.fetch_start = 1'b0;
    next_s.o.fcpu_tick = 1'b0;
    next_s.o.wdt_tick = 1'b0;
    rval = 32'h0000_0000;
    // pin synchronisers
    next_s.pin_s1 = ext_reset_pin_n;
    next_s.pin_s2 = s.pin_s1;
    next_s.wk_s1 = wake_pin;
    next_s.wk_s2 = s.wk_s1;

    sleep = (s.st == cmrc_pkg::ST_RUN) &&
      (s.mode.cpu_operating_mode == `CMRC_CPUM_SLEEP);
    green = (s.st == cmrc_pkg::ST_RUN) &&
      (s.mode.cpu_operating_mode == `CMRC_CPUM_GREEN);
    // reserved code 11 runs as normal
    executing = (s.st == cmrc_pkg::ST_RUN) && !sleep && !green;

    // internal rc oscillators modelled as tick dividers of aclk
    hi_tick = s.o.high_osc_en && (s.hcnt == HLIM - 13'h0001);
    lo_tick = s.o.low_osc_en && (s.lcnt == LLIM - 13'h0001);
    next_s.hcnt = div_step(s.hcnt, HLIM, s.o.high_osc_en);
    next_s.lcnt = div_step(s.lcnt, LLIM, s.o.low_osc_en);
    next_s.o.wdt_tick = lo_tick;

    ////////////////////////////////////////////////////////////////////////
    // instruction clock

    src_tick = s.o.sys_clk_src ? lo_tick : hi_tick;
    new_tick = s.mode.clock_source_select ? lo_tick : hi_tick;
    if (s.o.sys_clk_src || s.cfg.noise_filter)
      div_lim = `CMRC_LOW_DIV;
    else
      div_lim = s.cfg.fcpu_nsel;
    if (s.mode.clock_source_select != s.o.sys_clk_src)
    begin
      // hand over only on an edge of the new source, period restarts
      if (new_tick)
      begin
        next_s.o.sys_clk_src = s.mode.clock_source_select;
        next_s.fcnt = 2'h0;
      end
    end
    else if (src_tick)
    begin
      if (s.fcnt >= div_lim)
      begin
        next_s.fcnt = 2'h0;
        next_s.o.fcpu_tick = executing;
      end
      else
        next_s.fcnt = s.fcnt + 2'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write

    if (s.bvalid && bready)
      next_s.bvalid = 1'b0;
    if (awvalid && s.awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.widx = awaddr[`CMRC_AXI_AW-1:2];
    end
    if (wvalid && s.wready)
    begin
      next_s.w_got = 1'b1;
      next_s.wdat = wdata[7:0];
      next_s.wstb = wstrb[0];
    end
    wsel = reg_sel(next_s.widx);
    if (next_s.aw_got && next_s.w_got)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `CMRC_RESP_OKAY;
      if (wsel == 2'h0)
      begin
        if (next_s.wstb)
          next_s.mode = next_s.wdat[`CMRC_CPUM_HI:`CMRC_HIGH_OSC_STOP_BIT];
      end
      else if (wsel == 2'h1)
      begin
        if (next_s.wstb)
          next_s.cfg = next_s.wdat[`CMRC_CFG_WDT_BIT:`CMRC_CFG_NSEL_LO];
      end
      else if (wsel == 2'h3)
        next_s.bresp = `CMRC_RESP_SLVERR;
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read

    if (s.rvalid && rready)
      next_s.rvalid = 1'b0;
    rsel = reg_sel(araddr[`CMRC_AXI_AW-1:2]);
    if (rsel == 2'h0)
      rval = {27'h0000000, s.mode, 1'b0};
    else if (rsel == 2'h1)
      rval = {27'h0000000, s.cfg};
    else if (rsel == 2'h2)
      rval = {23'h000000, executing, s.o.sys_clk_src, s.o.low_osc_en,
        s.o.high_osc_en, s.st};
    if (arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rval;
      next_s.rresp = (rsel == 2'h3) ? `CMRC_RESP_SLVERR : `CMRC_RESP_OKAY;
    end
    next_s.arready = !next_s.rvalid;

    ////////////////////////////////////////////////////////////////////////
    // reset sequence and wakeup; hardware updates win over software writes

    case (s.st)
      cmrc_pkg::ST_HOLD:
      begin
        // stay while pin low and the reset function is on
        if (s.pin_s2 || !s.cfg.rst_pin_en)
          next_s.st = cmrc_pkg::ST_INIT;
      end
      cmrc_pkg::ST_INIT:
      begin
        next_s.mode = `CMRC_MODE_RST;
        next_s.o.sys_clk_src = 1'b0;
        next_s.fcnt = 2'h0;
        next_s.wcnt = 13'h0000;
        next_s.st = cmrc_pkg::ST_WARM;
      end
      cmrc_pkg::ST_WARM:
      begin
        next_s.mode = `CMRC_MODE_RST;
        if (hi_tick)
        begin
          next_s.wcnt = s.wcnt + 13'h0001;
          if (s.wcnt == WARM_LIM - 13'h0001)
          begin
            next_s.st = cmrc_pkg::ST_RUN;
            next_s.o.fetch_start = 1'b1;
          end
        end
      end
      cmrc_pkg::ST_RUN:
      begin
        if (sleep && s.wk_s2)
        begin
          next_s.st = cmrc_pkg::ST_WAKE;
          next_s.wcnt = 13'h0000;
        end
        else if (green && s.wk_s2)
          next_s.mode.cpu_operating_mode = `CMRC_CPUM_NORMAL;
      end
      cmrc_pkg::ST_WAKE:
      begin
        if (hi_tick)
        begin
          next_s.wcnt = s.wcnt + 13'h0001;
          if (s.wcnt == WAKE_LIM - 13'h0001)
          begin
            next_s.st = cmrc_pkg::ST_RUN;
            next_s.mode.cpu_operating_mode = `CMRC_CPUM_NORMAL;
            next_s.mode.clock_source_select = 1'b0;
          end
        end
      end
      default:
        next_s.st = cmrc_pkg::ST_HOLD;
    endcase

    // low pin overrides every phase
    if (s.cfg.rst_pin_en && !s.pin_s2)
    begin
      next_s.st = cmrc_pkg::ST_HOLD;
      next_s.mode = `CMRC_MODE_RST;
      // no instruction tick or fetch may leave alongside a fresh reset
      next_s.o.fcpu_tick = 1'b0;
      next_s.o.fetch_start = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator enables and status outputs

    // sleep stops both; while running high also stopped by its bit, low in green on the low source with the watchdog off
    next_s.o.high_osc_en = !(next_s.st == cmrc_pkg::ST_RUN &&
      (next_s.mode.cpu_operating_mode == `CMRC_CPUM_SLEEP ||
       next_s.mode.high_osc_stop));
    next_s.o.low_osc_en = !(next_s.st == cmrc_pkg::ST_RUN &&
      (next_s.mode.cpu_operating_mode == `CMRC_CPUM_SLEEP ||
       (next_s.mode.cpu_operating_mode == `CMRC_CPUM_GREEN &&
        next_s.mode.clock_source_select && !next_s.cfg.wdt_en)));
    next_s.o.sys_reset_n = (next_s.st == cmrc_pkg::ST_RUN) ||
      (next_s.st == cmrc_pkg::ST_WAKE);
    next_s.o.cpu_run = (next_s.st == cmrc_pkg::ST_RUN) &&
      (next_s.mode.cpu_operating_mode[0] == next_s.mode.cpu_operating_mode[1]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.st <= cmrc_pkg::ST_HOLD;
      s.cfg.fcpu_nsel <= FCPU_NSEL;
      s.cfg.noise_filter <= NOISE_FILTER;
      s.cfg.rst_pin_en <= RESET_PIN_EN;
      s.cfg.wdt_en <= WDT_EN;
      s.o.high_osc_en <= 1'b1;
      s.o.low_osc_en <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign clk_out = s.o;

endmodule : cmrc_top

`default_nettype wire

// File: verif/cmrc_props.sv
// port assertions of the clock and mode controller
`timescale 1ns/1ps
`default_nettype none
module cmrc_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire cmrc_pkg::cmrc_clk_out_t clk_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_cpu_gap;
    !clk_out.fcpu_tick [*8];
  endsequence
  sequence s_wdt_gap;
    !clk_out.wdt_tick [*8];
  endsequence
  ////////////////////////////////////////////////////////////
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_reset_quiet: assert property (
    !clk_out.sys_reset_n |-> !clk_out.cpu_run && !clk_out.fcpu_tick)
    else $error("cpu active in reset");
  a_fetch_pulse: assert property (
    clk_out.fetch_start |-> clk_out.sys_reset_n ##1 !clk_out.fetch_start)
    else $error("fetch start not a single pulse");
  a_sleep_halt: assert property (
    !clk_out.high_osc_en && !clk_out.low_osc_en |-> !clk_out.cpu_run)
    else $error("cpu runs with both oscillators off");
  a_low_src_run: assert property (
    clk_out.sys_clk_src && clk_out.cpu_run |-> clk_out.low_osc_en)
    else $error("low source without low oscillator");
  a_high_src_run: assert property (
    !clk_out.sys_clk_src && clk_out.cpu_run |-> clk_out.high_osc_en)
    else $error("high source without high oscillator");
  a_tick_pulse: assert property (clk_out.fcpu_tick |=> !clk_out.fcpu_tick)
    else $error("instruction tick longer than one cycle");
  a_slow_gap: assert property (clk_out.sys_clk_src && clk_out.fcpu_tick |=> s_cpu_gap)
    else $error("slow instruction ticks too close");
  a_wdt_gap: assert property (clk_out.wdt_tick |=> s_wdt_gap)
    else $error("watchdog ticks too close");
  a_low_stopped: assert property (!clk_out.low_osc_en [*2] |-> !clk_out.wdt_tick)
    else $error("watchdog tick with low oscillator off");
endmodule : cmrc_props
bind cmrc_top cmrc_props cmrc_props_inst (.aclk(aclk), .aresetn(aresetn), .bvalid(bvalid),
  .bready(bready), .bresp(bresp), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .clk_out(clk_out));
`default_nettype wire

// File: verif/cmrc_tb_top.sv
// self-checking bench of the clock and mode controller
`timescale 1ns/1ps
`default_nettype none
`include "cmrc_defines.svh"
module cmrc_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pin_n, wake;
  logic awready, wready, bvalid, arready, rvalid;
  logic [15:0] awaddr, araddr, ra;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [2:0] awprot, arprot;
  logic [1:0] bresp, rresp;
  cmrc_pkg::cmrc_clk_out_t co;
  logic [33:0] exp_q[$];
  int fail_count, n_compared, cyc, n, seed;
  localparam logic [15:0] A_MODE = {`CMRC_MODE_IDX, 2'b00};
  localparam logic [15:0] A_CFG = {`CMRC_CFG_IDX, 2'b00};
  localparam logic [15:0] A_STAT = {`CMRC_STAT_IDX, 2'b00};
  localparam logic [1:0] OK = `CMRC_RESP_OKAY;
  localparam logic [1:0] ER = `CMRC_RESP_SLVERR;
  cmrc_top #(.HIGH_CLOCK_OPTION_DIV(4), .LOSC_DIV(16), .WAKE_TICKS(8), .WARM_TICKS(8)) cmrc_top_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .ext_reset_pin_n(pin_n), .wake_pin(wake), .clk_out(co));
  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] want);
    n_compared++;
    if (seen !== want)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] r);
    logic ga, gw;
    int w;
    ga = 1'b0;
    gw = 1'b0;
    exp_q.push_back({32'h0, r});
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awprot <= 3'($random(seed));
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      ga = ga | awready;
      gw = gw | wready;
      awvalid <= !ga;
      wvalid <= !gw;
    end
    while (!(ga && gw));
    // late bready lets the response stall
    w = $unsigned($random(seed)) % 3;
    repeat (w) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [33:0] want);
    int w;
    exp_q.push_back(want);
    araddr <= a;
    arprot <= 3'($random(seed));
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    // late rready lets the read data stall
    w = $unsigned($random(seed)) % 3;
    repeat (w) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic tick;
    do @(posedge aclk); while (co.fcpu_tick !== 1'b1);
  endtask : tick
  task automatic period(input int want);
    tick();
    tick();
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (co.fcpu_tick !== 1'b1);
    check("period", 34'(n), 34'(want));
  endtask : period
  task automatic pulse;
    wake <= 1'b1;
    repeat (4) @(posedge aclk);
    wake <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : pulse
  task automatic fetch;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (co.fetch_start !== 1'b1);
    check("warm", 34'(n > 32), 34'h1);
  endtask : fetch
  ////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc++;
    if (bvalid && bready)
      check("bresp", {32'h0, bresp}, exp_q.pop_front());
    if (rvalid && rready)
      check("rdata", {rresp, rdata}, exp_q.pop_front());
    if (cyc == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end
  initial
  begin
    seed = 32'hfa787d02;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, wake} = '0;
    {awaddr, araddr, wdata, wstrb, awprot, arprot} = '0;
    pin_n = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    fetch();
    rd(A_STAT, {OK, 32'h168});
    rd(A_MODE, {OK, 32'h0});
    rd(A_CFG, {OK, 32'h1b});
    for (int i = 0; i < 5; i++)
    begin
      wr(A_CFG, 32'h18 + i, 4'hf, OK);
      period((i == 4) ? 16 : 4 * (i + 1));
    end
    wr(A_CFG, 32'h1b, 4'hf, OK);
    wr(A_MODE, ($random(seed) & 32'hffffff00) | 32'h04, 4'hf, OK);
    period(64);
    rd(A_STAT, {OK, 32'h1e8});
    wr(A_MODE, 32'h06, 4'hf, OK);
    rd(A_STAT, {OK, 32'h1c8});
    rd(A_MODE, {OK, 32'h06});
    wr(A_MODE, 32'h04, 4'hf, OK);
    wr(A_MODE, 32'h00, 4'hf, OK);
    period(16);
    wr(A_MODE, 32'h18, 4'hf, OK);
    period(16);
    wr(A_MODE, 32'h10, 4'hf, OK);
    rd(A_STAT, {OK, 32'h68});
    pulse();
    rd(A_MODE, {OK, 32'h0});
    wr(A_CFG, 32'h0b, 4'hf, OK);
    wr(A_MODE, 32'h04, 4'hf, OK);
    period(64);
    wr(A_MODE, 32'h14, 4'hf, OK);
    check("lowosc", 34'(co.low_osc_en), 34'h0);
    pulse();
    rd(A_STAT, {OK, 32'h1e8});
    wr(A_CFG, 32'h1b, 4'hf, OK);
    wr(A_MODE, 32'h08, 4'hf, OK);
    check("osc", 34'({co.high_osc_en, co.low_osc_en}), 34'h0);
    wake <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (co.cpu_run !== 1'b1);
    check("wake", 34'(n > 32), 34'h1);
    wake <= 1'b0;
    rd(A_MODE, {OK, 32'h0});
    ra = 16'($random(seed)) & 16'h00fc;
    rd(ra, {ER, 32'h0});
    wr(ra, 32'h04, 4'hf, ER);
    wr(A_MODE, 32'h04, 4'he, OK);
    rd(A_MODE, {OK, 32'h0});
    wr(A_MODE, 32'h04, 4'hf, OK);
    pin_n <= 1'b0;
    repeat (8) @(posedge aclk);
    check("pinrst", 34'(co.sys_reset_n), 34'h0);
    pin_n <= 1'b1;
    fetch();
    rd(A_MODE, {OK, 32'h0});
    wr(A_CFG, 32'h13, 4'hf, OK);
    pin_n <= 1'b0;
    repeat (8) @(posedge aclk);
    check("pinoff", 34'(co.sys_reset_n), 34'h1);
    pin_n <= 1'b1;
    repeat (4) @(posedge aclk);
    stop_test();
  end
endmodule : cmrc_tb_top
`default_nettype wire
